// ==== sec_bus_agent.sv ====
// Purpose: secondary bus agents that raise events and error lines
// Assumes: same clock as the register block, one command at a time
// Notes: error lines are pulled up, so a released line reads high
`timescale 1ns/1ps
`default_nettype none

module sec_bus_agent (
  // clock and command from the bench
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [2:0] kind_i,
  // event strobes and pulled-up lines
  output logic [3:0] pulse_o,
  output logic serr_n_o,
  output logic perr_n_o
);
  logic [3:0] pulse_reg = 4'h0; // one-cycle event strobes
  logic [2:0] serr_cnt = 3'h0; // cycles left with error line low
  logic [2:0] perr_cnt = 3'h0; // cycles left with parity line low

  // kinds 0 to 3 are one-cycle events of the bus engine
  always_ff @(posedge clk_i) begin
    pulse_reg <= (go_i && !kind_i[2]) ? 4'h1 << kind_i[1:0] : 4'h0;
  end

  // kind 4 holds the error line low long enough to cross the sync
  always_ff @(posedge clk_i) begin
    if (go_i && kind_i == 3'h4) begin
      serr_cnt <= 3'h4;
    end else if (serr_cnt != 3'h0) begin
      serr_cnt <= serr_cnt - 3'h1;
    end
  end

  // kind 5 does the same on the parity line
  always_ff @(posedge clk_i) begin
    if (go_i && kind_i == 3'h5) begin
      perr_cnt <= 3'h4;
    end else if (perr_cnt != 3'h0) begin
      perr_cnt <= perr_cnt - 3'h1;
    end
  end

  // released lines float up to the pull-up level
  assign pulse_o = pulse_reg;
  assign serr_n_o = (serr_cnt == 3'h0);
  assign perr_n_o = (perr_cnt == 3'h0);
endmodule : sec_bus_agent

`default_nettype wire

// ==== sec_status_pkg.sv ====
// Purpose: shared constants of the secondary bus status register block
// Assumes: classic wishbone, 32-bit data, one word per register
// Notes: indices are register indices; the byte address is four times
package sec_status_pkg;

  // register indices, byte address = index * 4
  localparam logic [7:0] IDX_SEC_STATUS = 8'h1E;
  localparam logic [7:0] IDX_BRIDGE_CTRL = 8'h3E;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h40;

  // event bit positions in the status word
  localparam int BIT_PARITY = 15;
  localparam int BIT_SYSERR = 14;
  localparam int BIT_RECEIVED_INITIATOR_ABORT = 13;
  localparam int BIT_RECEIVED_RESPONDER_ABORT = 12;
  localparam int BIT_SIGNALED_RESPONDER_ABORT = 11;
  localparam int BIT_INITIATOR_DATA_PARITY_FAULT = 8;

  // fixed and strap field positions
  localparam int BIT_SPEED_HI = 10;
  localparam int BIT_SPEED_LO = 9;
  localparam int BIT_FBB = 7;
  localparam int BIT_HIGH_SPEED = 5;

  // bridge control field position
  localparam int BIT_PAR_EN = 0;

  // fixed field values
  localparam logic [1:0] SPEED_MEDIUM = 2'h1;
  localparam logic FBB_VALUE = 1'h1;

  // bits that hold sticky events
  localparam logic [15:0] EVENT_MASK = 16'hF900;

  // reset values
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic PAR_EN_RST = 1'h0;

  // pin synchroniser slots and their idle reset value
  localparam int SYNC_SERR = 0;
  localparam int SYNC_PERR = 1;
  localparam int SYNC_STRAP = 2;
  localparam logic [2:0] SYNC_RST = 3'h3;

endpackage : sec_status_pkg

// ==== secondary_bus_status_reg.sv ====
// Purpose: secondary bus status register with event capture and irq
// Assumes: event pulses come from secondary bus logic on clk_i
// Notes: line and strap pins are synchronised before use
//
// Functional notes
// - status event bits clear on written one
// - parity fault always sets bit fifteen
// - system error line low sets bit fourteen
// - initiator abort received sets bit thirteen
// - responder abort received sets bit twelve
// - responder abort signalled sets bit eleven
// - bits ten to nine read medium timing
// - data parity bit needs master, line, enable
// - bit seven reads one, back to back
// - reserved bits six, four to zero zero
// - bit five follows the high speed strap
`timescale 1ns/1ps
`default_nettype none

module secondary_bus_status_reg #(
  parameter int ADR_W = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // event pulses and the master flag from the secondary bus engine
  input wire logic detected_parity_fault_i,
  input wire logic received_initiator_abort_i,
  input wire logic received_responder_abort_i,
  input wire logic signaled_responder_abort_i,
  input wire logic bridge_is_initiator_i,
  // secondary bus pins, active low lines and the high speed strap
  input wire logic downstream_system_error_line_n_i,
  input wire logic downstream_parity_error_line_n_i,
  input wire logic high_speed_strap_i,
  // control and interrupt
  output logic parity_response_enable_o,
  output logic irq_o
);

  // true when the bus address selects the register index
  function automatic logic hit(input logic [ADR_W-1:0] adr,
                               input logic [7:0] idx);
    hit = (adr == ADR_W'({idx, 2'h0}));
  endfunction : hit

  // bus state
  logic ack_reg; // one-cycle acknowledge
  logic [31:0] dat_reg; // read data held for the ack cycle
  logic req; // live request
  logic wr_take; // write commits at the acked edge
  logic [15:0] lane_en; // byte lanes enabled by sel
  logic [15:0] lane_data; // write data with disabled lanes zeroed

  // pin synchroniser stages
  logic [2:0] meta_reg; // first stage, read only by sync_reg
  logic [2:0] sync_reg; // second stage, safe to use

  // register contents
  logic [15:0] status_reg; // sticky event bits
  logic [15:0] status_next;
  logic [15:0] set_vec; // events seen this cycle
  logic [15:0] clr_vec; // bits written with one
  logic [15:0] status_view; // full word as software sees it
  logic [15:0] mask_reg; // interrupt mask, same layout
  logic [15:0] mask_next;
  logic par_en_reg; // parity response enable
  logic [31:0] rd_value; // read mux output

  // request and lane decode
  always_comb begin
    req = wb_cyc_i & wb_stb_i;
    wr_take = req & wb_we_i & ack_reg;
    lane_en = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    lane_data = wb_dat_i[15:0] & lane_en;
  end

  // acknowledge one cycle after the request is seen
  // unmapped addresses are acked too, so a stray access never hangs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'h0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // two-flop synchroniser for the asynchronous pins
  // reset parks the lines idle: high for the low-active lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= sec_status_pkg::SYNC_RST;
      sync_reg <= sec_status_pkg::SYNC_RST;
    end else begin
      meta_reg <= {high_speed_strap_i,
                   downstream_parity_error_line_n_i,
                   downstream_system_error_line_n_i};
      sync_reg <= meta_reg;
    end
  end

  // event set vector
  // the line samples lag the engine flags by two cycles; the master
  // flag must cover that tail for the data parity bit to catch it
  always_comb begin
    set_vec = 16'h0000;
    set_vec[sec_status_pkg::BIT_PARITY] =
      detected_parity_fault_i;
    set_vec[sec_status_pkg::BIT_SYSERR] =
      ~sync_reg[sec_status_pkg::SYNC_SERR];
    set_vec[sec_status_pkg::BIT_RECEIVED_INITIATOR_ABORT] =
      received_initiator_abort_i;
    set_vec[sec_status_pkg::BIT_RECEIVED_RESPONDER_ABORT] =
      received_responder_abort_i;
    set_vec[sec_status_pkg::BIT_SIGNALED_RESPONDER_ABORT] =
      signaled_responder_abort_i;
    set_vec[sec_status_pkg::BIT_INITIATOR_DATA_PARITY_FAULT] = bridge_is_initiator_i &
      ~sync_reg[sec_status_pkg::SYNC_PERR] & par_en_reg;
  end

  // write-one-to-clear, limited to event bits
  always_comb begin
    clr_vec = 16'h0000;
    if (wr_take && hit(wb_adr_i, sec_status_pkg::IDX_SEC_STATUS)) begin
      clr_vec = lane_data & sec_status_pkg::EVENT_MASK;
    end
    // set wins over clear so an event in the clear cycle survives
    status_next = ((status_reg & ~clr_vec) | set_vec) &
                  sec_status_pkg::EVENT_MASK;
  end

  // sticky status bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= sec_status_pkg::STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  // status word with fixed and strap fields merged in
  // fixed bits are never stored, so a write cannot touch them
  always_comb begin
    status_view = status_reg & sec_status_pkg::EVENT_MASK;
    status_view[sec_status_pkg::BIT_SPEED_HI:
                sec_status_pkg::BIT_SPEED_LO] =
      sec_status_pkg::SPEED_MEDIUM;
    status_view[sec_status_pkg::BIT_FBB] =
      sec_status_pkg::FBB_VALUE;
    status_view[sec_status_pkg::BIT_HIGH_SPEED] =
      sync_reg[sec_status_pkg::SYNC_STRAP];
  end

  // interrupt mask, only event positions are writable
  always_comb begin
    mask_next = mask_reg;
    if (wr_take && hit(wb_adr_i, sec_status_pkg::IDX_IRQ_MASK)) begin
      mask_next = ((mask_reg & ~lane_en) | lane_data) &
                  sec_status_pkg::EVENT_MASK;
    end
  end

  // mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= sec_status_pkg::MASK_RST;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // bridge control: only the parity response enable is held here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      par_en_reg <= sec_status_pkg::PAR_EN_RST;
    end else if (wr_take && wb_sel_i[0] &&
                 hit(wb_adr_i, sec_status_pkg::IDX_BRIDGE_CTRL)) begin
      par_en_reg <= wb_dat_i[sec_status_pkg::BIT_PAR_EN];
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    rd_value = 32'h0000_0000;
    if (hit(wb_adr_i, sec_status_pkg::IDX_SEC_STATUS)) begin
      rd_value[15:0] = status_view;
    end else if (hit(wb_adr_i, sec_status_pkg::IDX_IRQ_MASK)) begin
      rd_value[15:0] = mask_reg;
    end else if (hit(wb_adr_i, sec_status_pkg::IDX_BRIDGE_CTRL)) begin
      rd_value[sec_status_pkg::BIT_PAR_EN] = par_en_reg;
    end
  end

  // read data captured as the ack is raised
  // it stands for the ack cycle; a status read shows the state one
  // edge before the ack, events in the ack cycle appear next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (req && !ack_reg) begin
      dat_reg <= rd_value;
    end
  end

  // outputs
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign parity_response_enable_o = par_en_reg;
  // level interrupt: any unmasked sticky bit
  assign irq_o = |(status_reg & mask_reg);

  // checks below watch only what this block drives
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // helper: a status read being taken
  logic rd_status;
  assign rd_status = wb_ack_o & req & ~wb_we_i &
                     hit(wb_adr_i, sec_status_pkg::IDX_SEC_STATUS);

  // helper: a status write being taken
  logic wr_status;
  assign wr_status = wr_take &
                     hit(wb_adr_i, sec_status_pkg::IDX_SEC_STATUS);

  // written ones clear unless an event sets them again
  AST_W1C_CLEARS: assert property (
    wr_status |=>
      ((status_reg & $past(clr_vec) & ~$past(set_vec)) == 16'h0000))
    else $error("written one did not clear status bit");

  // written zeros keep every bit
  AST_ZERO_KEEPS: assert property (
    wr_status && (lane_data == 16'h0000) |=>
      (status_reg == (($past(status_reg) | $past(set_vec)) &
                      sec_status_pkg::EVENT_MASK)))
    else $error("zero write changed status");

  // parity fault sets bit fifteen regardless of the enable
  AST_PARITY_SETS: assert property (
    detected_parity_fault_i |=> status_reg[15])
    else $error("parity fault not recorded");

  // system error line low, after two sync stages, sets bit fourteen
  AST_SERR_SETS: assert property (
    !downstream_system_error_line_n_i [*3] |=> status_reg[14])
    else $error("system error line not recorded");

  // abort events set their bits
  AST_ABORTS_SET: assert property (
    received_initiator_abort_i |=> status_reg[13])
    else $error("initiator abort not recorded");

  AST_RX_ABORT_SET: assert property (
    received_responder_abort_i |=> status_reg[12])
    else $error("received responder abort not recorded");

  AST_TX_ABORT_SET: assert property (
    signaled_responder_abort_i |=> status_reg[11])
    else $error("signalled responder abort not recorded");

  // data parity bit rises only with all three causes
  AST_INITIATOR_DATA_PARITY_FAULT_CAUSE: assert property (
    $rose(status_reg[8]) |->
      $past(bridge_is_initiator_i) && $past(par_en_reg) &&
      !$past(sync_reg[1]))
    else $error("data parity bit set without its causes");

  // fixed fields read back as documented
  AST_FIXED_READ: assert property (
    rd_status |-> (wb_dat_o[10:9] == 2'h1) && wb_dat_o[7] &&
                  (wb_dat_o[31:16] == 16'h0000))
    else $error("fixed status fields wrong");

  // reserved bits read zero
  AST_RESERVED_ZERO: assert property (
    rd_status |-> (wb_dat_o[6] == 1'h0) && (wb_dat_o[4:0] == 5'h00))
    else $error("reserved status bits not zero");

  // strap bit matches the pin held for four cycles
  AST_STRAP_READ: assert property (
    $stable(high_speed_strap_i) [*4] ##1 rd_status |->
      wb_dat_o[5] == $past(high_speed_strap_i, 2))
    else $error("speed capability bit does not follow strap");

  // a write of ones to fixed bits leaves them readable unchanged
  AST_FIXED_WRITE: assert property (
    wr_status && (lane_data[10:9] != 2'h1) ##1 1'h1 |->
      (status_view[10:9] == 2'h1) && status_view[7])
    else $error("fixed bits changed by write");

  // ack lasts exactly one cycle and follows a request
  AST_ACK_PULSE: assert property (
    wb_ack_o |-> $past(req) ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");

  // an unmasked event raises the interrupt on the next cycle
  AST_IRQ_RAISE: assert property (
    detected_parity_fault_i && mask_reg[15] && !wr_take |=> irq_o)
    else $error("interrupt not raised for unmasked event");

  // helper: a read of an address that maps to no register
  // such reads are acked so a stray access never stalls the bus
  logic rd_unmapped;
  assign rd_unmapped = wb_ack_o & req & ~wb_we_i &
                       ~hit(wb_adr_i, sec_status_pkg::IDX_SEC_STATUS) &
                       ~hit(wb_adr_i, sec_status_pkg::IDX_IRQ_MASK) &
                       ~hit(wb_adr_i, sec_status_pkg::IDX_BRIDGE_CTRL);

  // unmapped reads return an all-zero word
  AST_UNMAPPED_ZERO: assert property (
    rd_unmapped |-> (wb_dat_o == 32'h0000_0000))
    else $error("unmapped read returned data");

  // a control write with lane zero enabled updates the enable
  AST_PAR_EN_WRITE: assert property (
    wr_take && wb_sel_i[0] &&
      hit(wb_adr_i, sec_status_pkg::IDX_BRIDGE_CTRL) |=>
      (parity_response_enable_o == $past(wb_dat_i[0])))
    else $error("parity response enable not written");

  // a full-lane mask write keeps only the event positions
  AST_MASK_WRITE: assert property (
    wr_take && (wb_sel_i == 4'hF) &&
      hit(wb_adr_i, sec_status_pkg::IDX_IRQ_MASK) |=>
      (mask_reg == ($past(wb_dat_i[15:0]) & 16'hF900)))
    else $error("mask write stored wrong bits");

  // a status write with the upper lane off clears no event bit
  AST_LANE_GUARD: assert property (
    wr_status && !wb_sel_i[1] |=>
      ((status_reg & 16'hFF00) ==
       (($past(status_reg) | $past(set_vec)) & 16'hF900)))
    else $error("disabled lane cleared status bits");

endmodule : secondary_bus_status_reg

`default_nettype wire

// ==== tb_secondary_bus_status_reg.sv ====
// Purpose: bench for the secondary bus status register block
// Assumes: classic wishbone master tasks, agent model raises events
// Notes: expected words are built from the package fixed field values
`timescale 1ns/1ps
`default_nettype none

module tb_secondary_bus_status_reg;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic go = 1'b0; // agent command strobe
  logic [2:0] kind = 3'h0; // agent command kind
  logic [3:0] pulse;
  logic serr_n;
  logic perr_n;
  logic master = 1'b0; // bridge owns the secondary bus
  logic strap = 1'b1; // high speed strap level
  logic par_en;
  logic irq;
  logic [31:0] rd; // last read word
  logic [3:0] sel_use = 4'hF; // byte lanes used by the next cycle
  logic [15:0] ev [4] = '{16'h8000, 16'h2000, 16'h1000, 16'h0800};
  int fail_count = 0;
  int compares = 0;

  always #5 clk_i = ~clk_i;

  secondary_bus_status_reg #(.ADR_W(10)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .detected_parity_fault_i(pulse[0]),
    .received_initiator_abort_i(pulse[1]),
    .received_responder_abort_i(pulse[2]),
    .signaled_responder_abort_i(pulse[3]),
    .bridge_is_initiator_i(master),
    .downstream_system_error_line_n_i(serr_n),
    .downstream_parity_error_line_n_i(perr_n),
    .high_speed_strap_i(strap), .parity_response_enable_o(par_en),
    .irq_o(irq));

  sec_bus_agent agent (.clk_i(clk_i), .go_i(go), .kind_i(kind),
    .pulse_o(pulse), .serr_n_o(serr_n), .perr_n_o(perr_n));

  // verdict and end of run
  task automatic stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic check_word(input string what, input logic [31:0] exp);
    compares++;
    if (rd !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, rd);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // one classic cycle; waits for ack under a bound
  task automatic wb_io(input logic we, input logic [7:0] idx,
                       input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= sel_use;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask : wb_io

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    wb_io(1'b0, idx, 32'h0);
    check_word($sformatf("reg %h", idx), exp);
  endtask : rd_chk

  // agent event, then time for sync and capture
  task automatic fire(input logic [2:0] k);
    @(posedge clk_i);
    go <= 1'b1;
    kind <= k;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : fire

  // fixed fields: medium timing, back to back, strap echo
  function automatic logic [31:0] base();
    return {21'h0, sec_status_pkg::SPEED_MEDIUM, 1'b0,
            sec_status_pkg::FBB_VALUE, 1'b0, strap, 5'h0};
  endfunction : base

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd_chk(8'h1E, base());
    wb_io(1'b1, 8'h1E, 32'h0000FFFF);
    rd_chk(8'h1E, base());
    strap <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd_chk(8'h1E, base());
    wb_io(1'b1, 8'h10, 32'h0000FFFF);
    rd_chk(8'h10, 32'h0);
    wb_io(1'b1, 8'h40, 32'h0000FFFF);
    rd_chk(8'h40, 32'h0000F900);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      fire(3'(i));
      rd_chk(8'h1E, base() | ev[i]);
      check_bit("irq", 1'b1, irq);
      wb_io(1'b1, 8'h1E, 32'h0000FFFF & ~ev[i]);
      rd_chk(8'h1E, base() | ev[i]);
      wb_io(1'b1, 8'h1E, {16'h0, ev[i]});
      rd_chk(8'h1E, base());
      check_bit("irq", 1'b0, irq);
    end
    $display("test events done");
    fire(3'h0);
    wb_io(1'b1, 8'h1E, 32'h0);
    rd_chk(8'h1E, base() | 32'h00008000);
    sel_use = 4'h1;
    wb_io(1'b1, 8'h1E, 32'h0000FFFF);
    sel_use = 4'hF;
    rd_chk(8'h1E, base() | 32'h00008000);
    wb_io(1'b1, 8'h1E, 32'h00008000);
    rd_chk(8'h1E, base());
    $display("test lanes done");
    wb_io(1'b1, 8'h40, 32'h0);
    fire(3'h0);
    check_bit("irq masked", 1'b0, irq);
    fire(3'h4);
    rd_chk(8'h1E, base() | 32'h0000C000);
    wb_io(1'b1, 8'h1E, 32'h0000C000);
    rd_chk(8'h1E, base());
    $display("test lines done");
    for (int j = 0; j < 3; j++) begin
      master <= (j != 0);
      wb_io(1'b1, 8'h3E, {31'h0, j != 1});
      @(posedge clk_i); // enable settles after the acked edge
      check_bit("parity enable", j != 1, par_en);
      fire(3'h5);
      rd_chk(8'h1E, base() | (j == 2 ? 32'h100 : 32'h0));
      wb_io(1'b1, 8'h1E, 32'h00000100);
    end
    $display("test data parity done");
    stop_test();
  end
endmodule : tb_secondary_bus_status_reg

`default_nettype wire
